// ### rtl/bkr_pkg.sv
package bkr_pkg;
    // register offsets on the byte-wide register port
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_SET1 = 3'h1;
    localparam logic [2:0] ADDR_SET2 = 3'h2;
    localparam logic [2:0] ADDR_OUTPUT_VOLTAGE_CODE = 3'h3;
    localparam logic [2:0] ADDR_CMD = 3'h4;
    // status field positions
    localparam int ST_OC = 7;
    localparam int ST_TSD = 6;
    localparam int ST_TWRN = 5;
    localparam int ST_RSV4 = 4;
    localparam int ST_EN = 3;
    localparam int ST_ONE = 2;
    localparam int ST_NOFLT = 1;
    localparam int ST_PG = 0;
    // first settings register fields
    localparam int S1_CURRENT_LIMIT_CODE_LSB = 6;
    localparam int S1_FREQ_LSB = 3;
    // second settings register fields
    localparam int S2_DLY_LSB = 4;
    localparam int S2_MRG_LSB = 2;
    localparam int S2_SS_LSB = 0;
    localparam int CMD_CLR = 0;
    // factory defaults loaded at power-up
    localparam logic [1:0] RST_CURRENT_LIMIT_CODE = 2'h0;
    localparam logic [2:0] RST_FREQ = 3'h0;
    localparam logic [2:0] RST_DLY = 3'h0;
    localparam logic [1:0] RST_MRG = 2'h0;
    localparam logic [1:0] RST_SS = 2'h0;
    localparam logic [7:0] RST_OUTPUT_VOLTAGE_CODE = 8'h00;
    // start-up delay step of half a millisecond
    localparam int CLK_MHZ = 50;
    localparam int DLY_STEP_US = 500;
    localparam int DLY_STEP_CYC = DLY_STEP_US * CLK_MHZ;
    // margin direction codes driven to the reference
    localparam logic [1:0] MRG_NOM = 2'h0;
    localparam logic [1:0] MRG_MINUS = 2'h1;
    localparam logic [1:0] MRG_PLUS = 2'h2;

    typedef enum logic [1:0] {BKR_OFF, BKR_WAIT, BKR_ON} bkr_start_t;

    // latched fault flags
    typedef struct packed {
        logic oc;
        logic tsd;
        logic twrn;
    } bkr_flags_t;

    // whole state of the register bank
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic pg_s1;
        logic pg_s2;
        bkr_flags_t flt_s1;
        bkr_flags_t flt_s2;
        bkr_flags_t flags;
        logic [1:0] current_limit_code;
        logic [2:0] freq;
        logic [2:0] dly;
        logic [1:0] mrg;
        logic [1:0] ss;
        logic [7:0] output_voltage_code;
        logic clr;
        bkr_start_t start;
        logic [4:0] steps;
        logic [31:0] tick;
        logic [7:0] rdata;
    } bkr_state_t;
endpackage

// ### rtl/bkr_regs.sv
`timescale 1ns/1ps
// What this block does
// - fault flags set on their condition and stay set afterwards.
// - flags clear only on command bit 0 write at 4h or reset.
// - live status bits follow their condition and drop when it ends.
// - after reset status reads zero except bit 2 one, bit 1 no-fault.
// - status bit 7 latches any overcurrent event.
// - status bit 6 latches any thermal shutdown.
// - status bit 5 latches any thermal warning.
// - status bit 4 always reads zero.
// - status bit 3 mirrors the enable pin level.
// - status bit 0 mirrors the power-good pin level.
// - status register at 0h is read-only diagnostics.
// - first settings bits 7-6 hold the current-limit code.
// - first settings bits 5-3 hold the switching-frequency code.
// - first settings bits 2-0 read zero.
// - settings load factory defaults at reset; writes are not kept.
// - clear-faults bit returns to zero once flags are cleared.
// - start-up delay code delays power delivery after enable rises.
// - margin code changes any time: 00 nominal, 01 minus, else plus.
module bkr_regs #(
    parameter int STEP_CYC = bkr_pkg::DLY_STEP_CYC,
    parameter logic [1:0] DEF_CURRENT_LIMIT_CODE = bkr_pkg::RST_CURRENT_LIMIT_CODE,
    parameter logic [2:0] DEF_FREQ = bkr_pkg::RST_FREQ,
    parameter logic [2:0] DEF_DLY = bkr_pkg::RST_DLY,
    parameter logic [1:0] DEF_SS = bkr_pkg::RST_SS,
    parameter logic [7:0] DEF_OUTPUT_VOLTAGE_CODE = bkr_pkg::RST_OUTPUT_VOLTAGE_CODE
) (
    input wire logic clk_i, // 50 MHz clock
    input wire logic sys_rst_i, // power-on reset, async high
    input wire logic wr_en_i, // one-cycle write strobe
    input wire logic rd_en_i, // one-cycle read strobe
    input wire logic [2:0] addr_i, // register offset
    input wire logic [7:0] wdata_i, // write data
    output logic [7:0] rdata_o, // read data, one cycle after strobe
    input wire logic oc_fault_i, // overcurrent condition, async
    input wire logic tsd_fault_i, // thermal shutdown condition, async
    input wire logic twrn_fault_i, // thermal warning condition, async
    input wire logic enable_pin_i, // enable pin, async
    input wire logic power_good_pin_i, // power-good pin, async
    output logic [1:0] current_limit_code_o, // current-limit code
    output logic [2:0] freq_code_o, // switching frequency code
    output logic [1:0] margin_dir_o, // nominal, minus or plus margin
    output logic [1:0] softstart_code_o, // soft-start slope code
    output logic [7:0] output_voltage_code_o, // output voltage code
    output logic power_deliver_o // power stage run request
);
    // s holds every flop of the bank; next_s is its combinational copy
    bkr_pkg::bkr_state_t s;
    bkr_pkg::bkr_state_t next_s;
    logic [7:0] status;
    logic [4:0] dly_steps;

    // reset value is all constants: the factory defaults
    localparam bkr_pkg::bkr_state_t RST_S = '{
        en_s1: 1'b0, en_s2: 1'b0, pg_s1: 1'b0, pg_s2: 1'b0,
        flt_s1: '0, flt_s2: '0, flags: '0,
        current_limit_code: DEF_CURRENT_LIMIT_CODE, freq: DEF_FREQ, dly: DEF_DLY,
        mrg: bkr_pkg::RST_MRG, ss: DEF_SS, output_voltage_code: DEF_OUTPUT_VOLTAGE_CODE,
        clr: 1'b0, start: bkr_pkg::BKR_OFF, steps: 5'h00,
        tick: 32'h0000_0000, rdata: 8'h00};

    // status word assembled from flags and synchronised pins
    always_comb begin
        status = 8'h00;
        status[bkr_pkg::ST_OC] = s.flags.oc;
        status[bkr_pkg::ST_TSD] = s.flags.tsd;
        status[bkr_pkg::ST_TWRN] = s.flags.twrn;
        status[bkr_pkg::ST_EN] = s.en_s2;
        status[bkr_pkg::ST_ONE] = 1'b1;
        // derived, not stored, so it can never disagree with the flags
        status[bkr_pkg::ST_NOFLT] = (s.flags == '0);
        status[bkr_pkg::ST_PG] = s.pg_s2;
    end

    // delay code to half-millisecond steps: 0,1,2,4,8,12,16,20
    // steps are counted rather than cycles, so the step length can shrink in test
    always_comb begin
        unique case (s.dly)
            3'h0: dly_steps = 5'h00;
            3'h1: dly_steps = 5'h01;
            3'h2: dly_steps = 5'h02;
            3'h3: dly_steps = 5'h04;
            3'h4: dly_steps = 5'h08;
            3'h5: dly_steps = 5'h0c;
            3'h6: dly_steps = 5'h10;
            3'h7: dly_steps = 5'h14;
        endcase
    end

    // next state: synchronisers, flags, register writes, start-up sequencer
    always_comb begin
        next_s = s;
        // two flops on every pin before any logic looks at it
        next_s.en_s1 = enable_pin_i;
        next_s.en_s2 = s.en_s1;
        next_s.pg_s1 = power_good_pin_i;
        next_s.pg_s2 = s.pg_s1;
        next_s.flt_s1 = '{oc: oc_fault_i, tsd: tsd_fault_i, twrn: twrn_fault_i};
        next_s.flt_s2 = s.flt_s1;
        // a clear pending from last cycle empties the flags, then drops itself
        if (s.clr) begin
            next_s.flags = '0;
            next_s.clr = 1'b0;
        end
        // an event in the clearing cycle still sets its flag
        next_s.flags = next_s.flags | s.flt_s2;
        // writes; the status offset has no write path at all
        // settings apply even with enable high; holding enable low is the host's job
        if (wr_en_i) begin
            unique case (addr_i)
                bkr_pkg::ADDR_SET1: begin
                    next_s.current_limit_code = wdata_i[bkr_pkg::S1_CURRENT_LIMIT_CODE_LSB +: 2];
                    next_s.freq = wdata_i[bkr_pkg::S1_FREQ_LSB +: 3];
                end
                bkr_pkg::ADDR_SET2: begin
                    next_s.dly = wdata_i[bkr_pkg::S2_DLY_LSB +: 3];
                    next_s.mrg = wdata_i[bkr_pkg::S2_MRG_LSB +: 2];
                    next_s.ss = wdata_i[bkr_pkg::S2_SS_LSB +: 2];
                end
                bkr_pkg::ADDR_OUTPUT_VOLTAGE_CODE: next_s.output_voltage_code = wdata_i;
                bkr_pkg::ADDR_CMD: begin
                    if (wdata_i[bkr_pkg::CMD_CLR]) begin
                        next_s.clr = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // read data is registered; unmapped offsets read zero
        if (rd_en_i) begin
            unique case (addr_i)
                bkr_pkg::ADDR_STATUS: next_s.rdata = status;
                bkr_pkg::ADDR_SET1: next_s.rdata = {s.current_limit_code, s.freq, 3'h0};
                bkr_pkg::ADDR_SET2: next_s.rdata = {1'b0, s.dly, s.mrg, s.ss};
                bkr_pkg::ADDR_OUTPUT_VOLTAGE_CODE: next_s.rdata = s.output_voltage_code;
                bkr_pkg::ADDR_CMD: next_s.rdata = {7'h00, s.clr};
                default: next_s.rdata = 8'h00;
            endcase
        end
        // start-up sequencer; dropping enable always stops delivery at once
        // a delay code changed while waiting is used at once, so keep it stable
        unique case (s.start)
            bkr_pkg::BKR_OFF: begin
                next_s.tick = 32'h0000_0000;
                next_s.steps = 5'h00;
                if (s.en_s2) begin
                    next_s.start = bkr_pkg::BKR_WAIT;
                end
            end
            bkr_pkg::BKR_WAIT: begin
                if (!s.en_s2) begin
                    next_s.start = bkr_pkg::BKR_OFF;
                end else if (s.steps >= dly_steps) begin
                    next_s.start = bkr_pkg::BKR_ON;
                end else if (s.tick == 32'(STEP_CYC - 1)) begin
                    next_s.tick = 32'h0000_0000;
                    next_s.steps = s.steps + 5'h01;
                end else begin
                    next_s.tick = s.tick + 32'h0000_0001;
                end
            end
            bkr_pkg::BKR_ON: begin
                if (!s.en_s2) begin
                    next_s.start = bkr_pkg::BKR_OFF;
                end
            end
            default: next_s.start = bkr_pkg::BKR_OFF;
        endcase
    end

    // single state register; reset is the power cycle that restores defaults
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state flops
    assign rdata_o = s.rdata;
    assign current_limit_code_o = s.current_limit_code;
    assign freq_code_o = s.freq;
    assign softstart_code_o = s.ss;
    assign output_voltage_code_o = s.output_voltage_code;
    assign power_deliver_o = (s.start == bkr_pkg::BKR_ON);
    // 10 and 11 both mean plus
    assign margin_dir_o = (s.mrg == 2'h0) ? bkr_pkg::MRG_NOM :
                          (s.mrg == 2'h1) ? bkr_pkg::MRG_MINUS : bkr_pkg::MRG_PLUS;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence en_rise_s;
        !s.en_s2 ##1 s.en_s2;
    endsequence

    sequence wait_done_s;
        (s.start == bkr_pkg::BKR_WAIT) && s.en_s2 && (s.steps >= dly_steps);
    endsequence

    flag_hold_a: assert property ((s.flags.oc && !s.clr) |=> s.flags.oc)
        else $error("overcurrent flag dropped without a clear");
    flag_clear_a: assert property ((s.clr && s.flt_s2 == '0) |=> (s.flags == '0))
        else $error("flags survived a clear");
    oc_latch_a: assert property (oc_fault_i ##2 1'b1 |=> status[bkr_pkg::ST_OC])
        else $error("overcurrent not latched");
    tsd_latch_a: assert property (tsd_fault_i ##2 1'b1 |=> status[bkr_pkg::ST_TSD])
        else $error("thermal shutdown not latched");
    twrn_latch_a: assert property (twrn_fault_i ##2 1'b1 |=> status[bkr_pkg::ST_TWRN])
        else $error("thermal warning not latched");
    en_mirror_a: assert property (status[bkr_pkg::ST_EN] == $past(enable_pin_i, 2))
        else $error("enable status does not follow pin");
    pg_mirror_a: assert property (status[bkr_pkg::ST_PG] == $past(power_good_pin_i, 2))
        else $error("power-good status does not follow pin");
    fixed_bits_a: assert property (status[bkr_pkg::ST_ONE] && !status[bkr_pkg::ST_RSV4])
        else $error("fixed status bits wrong");
    no_fault_a: assert property (status[bkr_pkg::ST_NOFLT] == (s.flags == '0))
        else $error("no-fault bit disagrees with flags");
    status_ro_a: assert property ((wr_en_i && addr_i == bkr_pkg::ADDR_STATUS && !s.clr
        && s.flt_s2 == '0) |=> $stable(s.flags))
        else $error("status write disturbed flags");
    set1_low_a: assert property ((rd_en_i && addr_i == bkr_pkg::ADDR_SET1)
        |=> rdata_o[2:0] == 3'h0 && rdata_o[7:6] == $past(current_limit_code_o))
        else $error("first settings read back wrong");
    current_limit_code_write_a: assert property ((wr_en_i && addr_i == bkr_pkg::ADDR_SET1)
        |=> current_limit_code_o == $past(wdata_i[7:6])
        && freq_code_o == $past(wdata_i[5:3]))
        else $error("first settings write not taken");
    clr_self_a: assert property (s.clr |=> !s.clr)
        else $error("clear bit did not self-clear");
    margin_dir_a: assert property ((wr_en_i && addr_i == bkr_pkg::ADDR_SET2 && wdata_i[3])
        |=> margin_dir_o == bkr_pkg::MRG_PLUS)
        else $error("margin code 1x not plus");
    start_seq_a: assert property (en_rise_s ##1 wait_done_s |=> power_deliver_o)
        else $error("power delivery did not start after delay");
    start_gate_a: assert property ($rose(power_deliver_o) |-> $past(s.en_s2)
        && $past(s.start) == bkr_pkg::BKR_WAIT)
        else $error("power delivery started without delay phase");

    // a clear command taken at the register port
    sequence clr_cmd_s;
        wr_en_i && (addr_i == bkr_pkg::ADDR_CMD) && wdata_i[bkr_pkg::CMD_CLR];
    endsequence

    // the cycle after a clear: no fault at the second stage and no second clear
    sequence clr_settle_s;
        (s.flt_s2 == '0) && !(wr_en_i && (addr_i == bkr_pkg::ADDR_CMD));
    endsequence

    // a second settings write; margining may change while power runs
    sequence wr_set2_s;
        wr_en_i && (addr_i == bkr_pkg::ADDR_SET2);
    endsequence

    // the other two flags hold the same way as the overcurrent flag
    tsd_hold_a: assert property ((s.flags.tsd && !s.clr) |=> s.flags.tsd)
        else $error("thermal shutdown flag dropped without a clear");
    twrn_hold_a: assert property ((s.flags.twrn && !s.clr) |=> s.flags.twrn)
        else $error("thermal warning flag dropped without a clear");
    // a fault meeting a clear in the same edge keeps its flag: set wins
    set_wins_a: assert property ((s.clr && s.flt_s2 != '0)
        |=> (s.flags == $past(s.flt_s2)))
        else $error("fault lost against a clear");

    // a flag rises only for a fault seen at the second sync stage
    oc_cause_a: assert property ($rose(s.flags.oc) |-> $past(s.flt_s2.oc))
        else $error("overcurrent flag rose with no fault");
    tsd_cause_a: assert property ($rose(s.flags.tsd) |-> $past(s.flt_s2.tsd))
        else $error("thermal shutdown flag rose with no fault");
    twrn_cause_a: assert property ($rose(s.flags.twrn) |-> $past(s.flt_s2.twrn))
        else $error("thermal warning flag rose with no fault");

    // without a pending clear no flag may fall, whatever the host writes
    flag_keep_a: assert property (!s.clr
        |=> ((~s.flags & $past(s.flags)) == 3'h0))
        else $error("flag fell without a clear");
    clr_set_a: assert property (clr_cmd_s |=> s.clr)
        else $error("clear command not taken");
    clr_path_a: assert property (clr_cmd_s ##1 clr_settle_s
        |=> (s.flags == '0) && !s.clr)
        else $error("clear command did not empty the flags");

    // live bits drop two edges after their pin falls; nothing holds them
    en_live_a: assert property (!enable_pin_i ##2 1'b1 |-> !status[bkr_pkg::ST_EN])
        else $error("enable status held after the pin fell");
    pg_live_a: assert property (!power_good_pin_i ##2 1'b1 |-> !status[bkr_pkg::ST_PG])
        else $error("power-good status held after the pin fell");

    // read data carries what stood in the register at the strobe edge
    status_read_a: assert property ((rd_en_i && addr_i == bkr_pkg::ADDR_STATUS)
        |=> rdata_o == $past(status))
        else $error("status read back wrong");
    freq_read_a: assert property ((rd_en_i && addr_i == bkr_pkg::ADDR_SET1)
        |=> rdata_o[5:3] == $past(freq_code_o))
        else $error("frequency code read back wrong");
    cmd_read_a: assert property ((rd_en_i && addr_i == bkr_pkg::ADDR_CMD)
        |=> rdata_o == {7'h00, $past(s.clr)})
        else $error("command register read back wrong");

    // a write to the status offset touches no setting and starts no clear
    status_cfg_a: assert property ((wr_en_i && addr_i == bkr_pkg::ADDR_STATUS)
        |=> $stable({s.current_limit_code, s.freq, s.dly, s.mrg, s.ss, s.output_voltage_code}) && !s.clr)
        else $error("status write changed a setting");
    // written values stand until the next power cycle
    output_voltage_code_write_a: assert property ((wr_en_i && addr_i == bkr_pkg::ADDR_OUTPUT_VOLTAGE_CODE)
        |=> output_voltage_code_o == $past(wdata_i))
        else $error("output voltage write not taken");
    ss_write_a: assert property (wr_set2_s
        |=> softstart_code_o == $past(wdata_i[1:0]))
        else $error("soft-start write not taken");
    margin_minus_a: assert property (wr_set2_s ##0 (wdata_i[3:2] == 2'h1)
        |=> margin_dir_o == bkr_pkg::MRG_MINUS)
        else $error("margin code 01 not minus");
    margin_nom_a: assert property (wr_set2_s ##0 (wdata_i[3:2] == 2'h0)
        |=> margin_dir_o == bkr_pkg::MRG_NOM)
        else $error("margin code 00 not nominal");

    // first edge after a power cycle: factory defaults, no flags, no power
    reset_def_a: assert property ($fell(sys_rst_i)
        |-> current_limit_code_o == DEF_CURRENT_LIMIT_CODE && freq_code_o == DEF_FREQ
        && s.dly == DEF_DLY && softstart_code_o == DEF_SS
        && output_voltage_code_o == DEF_OUTPUT_VOLTAGE_CODE && margin_dir_o == bkr_pkg::MRG_NOM)
        else $error("settings not at factory defaults after reset");
    reset_flags_a: assert property ($fell(sys_rst_i)
        |-> (s.flags == '0) && status[bkr_pkg::ST_NOFLT] && !power_deliver_o)
        else $error("flags or power not clear after reset");

    // delivery stops with enable, and never starts before the delay is spent
    start_off_a: assert property (!s.en_s2 |=> !power_deliver_o)
        else $error("power delivery outlived the enable pin");
    wait_hold_a: assert property ((s.start == bkr_pkg::BKR_WAIT && s.steps < dly_steps)
        |=> !power_deliver_o)
        else $error("power delivery started before the delay ran out");
    // every enable rise starts from a fresh delay count
    off_idle_a: assert property ((s.start == bkr_pkg::BKR_OFF)
        |=> (s.tick == 32'h0000_0000) && (s.steps == 5'h00))
        else $error("delay count not cleared while off");
    tick_bound_a: assert property (s.tick < 32'(STEP_CYC))
        else $error("step counter ran past one step");
    steps_max_a: assert property (s.steps <= 5'h14)
        else $error("step count beyond the longest delay");
endmodule

// ### tb/bkr_host.sv
`timescale 1ns/1ps
// behavioural host: strobes launched at the falling edge, one byte per access
module bkr_host (
    input wire logic clk_i, // bank clock
    input wire logic [7:0] rdata_i, // read data from the bank
    output logic wr_en_o, // write strobe
    output logic rd_en_o, // read strobe
    output logic [2:0] addr_o, // register offset
    output logic [7:0] wdata_o, // write data
    output logic enable_o // enable pin level
);
    // idle bus at time zero
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 3'h0;
        wdata_o = 8'h00;
        enable_o = 1'b0;
    end
    // data is inverted once released so a stale byte cannot pass for a fresh one
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wdata_o = ~d;
    endtask
    // read data is taken one cycle after the strobe edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        rd_en_o = 1'b0;
        d = rdata_i;
    endtask
    task automatic set_en(input logic v);
        @(negedge clk_i);
        enable_o = v;
    endtask
    // first settings change after enable drops, one edge before power delivery stops
    task automatic cfg1(input logic [7:0] d);
        set_en(1'b0);
        wr(3'h1, d);
        set_en(1'b1);
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] r;
    } bkr_row_t;
    localparam int STEP = 4;
    logic clk_i = 1'b0;
    logic sys_rst_i;
    logic oc, tsd, twrn, pg;
    logic wr_en, rd_en, en, pwr;
    logic [2:0] addr, freq;
    logic [7:0] wdata, rdata, rv, output_voltage_code;
    logic [1:0] current_limit_code, mrg, ss;
    int n_mismatch = 0;
    int total_checks = 0;
    int cnt;
    int steps [8] = '{0, 1, 2, 4, 8, 12, 16, 20};
    // write then read back; reserved bits, status and unmapped places included
    bkr_row_t rows [8] = '{'{3'h1, 8'hcf, 8'hc8}, '{3'h2, 8'hff, 8'h7f},
        '{3'h3, 8'ha5, 8'ha5}, '{3'h4, 8'hfe, 8'h00}, '{3'h0, 8'hff, 8'h06},
        '{3'h5, 8'hff, 8'h00}, '{3'h1, 8'h07, 8'h00}, '{3'h2, 8'h00, 8'h00}};

    always #10 clk_i = ~clk_i;

    // non-zero factory defaults so a missed reload shows up
    bkr_regs #(.STEP_CYC(STEP), .DEF_CURRENT_LIMIT_CODE(2'h2), .DEF_FREQ(3'h5), .DEF_DLY(3'h3),
        .DEF_SS(2'h1), .DEF_OUTPUT_VOLTAGE_CODE(8'h3c)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .oc_fault_i(oc),
        .tsd_fault_i(tsd), .twrn_fault_i(twrn), .enable_pin_i(en),
        .power_good_pin_i(pg), .current_limit_code_o(current_limit_code), .freq_code_o(freq),
        .margin_dir_o(mrg), .softstart_code_o(ss), .output_voltage_code_o(output_voltage_code),
        .power_deliver_o(pwr));

    bkr_host host (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata), .enable_o(en));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk(nm, e, rv);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst_i = 1'b1;
        oc = 1'b0;
        tsd = 1'b0;
        twrn = 1'b0;
        pg = 1'b0;
        repeat (16) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rchk("status at power-up", 3'h0, 8'h06);
        foreach (rows[k]) begin
            host.wr(rows[k].a, rows[k].d);
            rchk("readback", rows[k].a, rows[k].r);
        end
        // every limit and frequency code reaches the outputs
        for (int i = 0; i < 8; i++) begin
            host.wr(3'h1, {i[1:0], i[2:0], 3'h7});
            chk("limit code", {6'h0, i[1:0]}, {6'h0, current_limit_code});
            chk("freq code", {5'h0, i[2:0]}, {5'h0, freq});
        end
        // margin codes, written as power delivery starts; it runs from the code 01 write on
        host.cfg1(8'hcf);
        chk("limit after cfg", 8'h03, {6'h0, current_limit_code});
        for (int i = 0; i < 4; i++) begin
            host.wr(3'h2, {4'h0, i[1:0], i[1:0]});
            chk("margin", (i == 0) ? 8'h0 : (i == 1) ? 8'h1 : 8'h2, {6'h0, mrg});
            chk("softstart", {6'h0, i[1:0]}, {6'h0, ss});
        end
        host.wr(3'h3, 8'h5a);
        chk("output_voltage_code", 8'h5a, output_voltage_code);
        // live pin bits follow the pins both ways
        pg = 1'b1;
        repeat (3) @(negedge clk_i);
        rchk("pins high", 3'h0, 8'h0f);
        pg = 1'b0;
        host.set_en(1'b0);
        repeat (3) @(negedge clk_i);
        rchk("pins low", 3'h0, 8'h06);
        // each flag outlives its cause and survives a status write
        for (int i = 0; i < 3; i++) begin
            oc = (i == 0);
            tsd = (i == 1);
            twrn = (i == 2);
            repeat (4) @(negedge clk_i);
            oc = 1'b0;
            tsd = 1'b0;
            twrn = 1'b0;
            repeat (4) @(negedge clk_i);
            rchk("flag", 3'h0, (8'h80 >> i) | 8'h04);
            host.wr(3'h0, 8'h00);
            rchk("flag kept", 3'h0, (8'h80 >> i) | 8'h04);
            host.wr(3'h4, 8'h01);
            rchk("cleared", 3'h0, 8'h06);
            rchk("clear bit", 3'h4, 8'h00);
        end
        // start-up delay for every code; the wait is bounded
        for (int i = 0; i < 8; i++) begin
            host.wr(3'h2, {1'b0, i[2:0], 4'h0});
            host.set_en(1'b1);
            cnt = 0;
            while (pwr !== 1'b1 && cnt < 200) begin
                @(negedge clk_i);
                cnt++;
            end
            if (cnt >= 200) begin
                n_mismatch++;
                finish_test();
            end
            chk("delay ok", 8'h1, {7'h0, (cnt >= steps[i] * STEP + 2)
                && (cnt <= steps[i] * STEP + 6)});
            host.set_en(1'b0);
            repeat (4) @(negedge clk_i);
            chk("power off", 8'h0, {7'h0, pwr});
        end
        // a latched flag and written settings are lost on a power cycle
        oc = 1'b1;
        repeat (4) @(negedge clk_i);
        oc = 1'b0;
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("limit default", 8'h02, {6'h0, current_limit_code});
        chk("output_voltage_code default", 8'h3c, output_voltage_code);
        chk("margin default", 8'h00, {6'h0, mrg});
        chk("freq default", 8'h05, {5'h0, freq});
        chk("softstart default", 8'h01, {6'h0, ss});
        rchk("set1 default", 3'h1, 8'ha8);
        rchk("set2 default", 3'h2, 8'h31);
        rchk("status reset", 3'h0, 8'h06);
        finish_test();
    end
endmodule
